// ---- core/pmdc_defs.vh ----
// constants for the panel menu and display control block
`ifndef PMDC_DEFS_VH
`define PMDC_DEFS_VH
// register byte offsets
`define PMDC_A_CTRL 5'h00
`define PMDC_A_PASS 5'h04
`define PMDC_A_TMO 5'h08
`define PMDC_A_PER 5'h0C
`define PMDC_A_ADDR 5'h10
`define PMDC_A_STAT 5'h14
// ctrl fields, reset values and the timeout limit
`define PMDC_CTRL_ROLE 0
`define PMDC_CTRL_SLIDE 1
`define PMDC_RST_PER 14'h0001
`define PMDC_RST_ADDR 8'h01
`define PMDC_MAX_TMO 16'h0063
// clock rate and times
`define PMDC_CLK_KHZ 200000
`define PMDC_DEB_MS 10
`define PMDC_LONG_MS 2000
`define PMDC_SEC_MS 1000
`define PMDC_ID_MS 1500
`define PMDC_ERR_MS 1000
`define PMDC_SLIDE_MS 400
`define PMDC_IDLE_S 6'h3C
// display range limits
`define PMDC_HI4 32'h0000_270F
`define PMDC_LO4 32'hFFFF_FC19
`define PMDC_HI6 32'h000F_423F
`define PMDC_LO6 32'hFFFE_7961
// display codes
`define PMDC_D_ID 4'h0
`define PMDC_D_DASH 4'h1
`define PMDC_D_VAL 4'h2
`define PMDC_D_OVER 4'h3
`define PMDC_D_UNDER 4'h4
`define PMDC_D_PASS 4'h5
`define PMDC_D_ERR 4'h6
`define PMDC_D_ITEM 4'h7
`define PMDC_D_EDIT 4'h8
`define PMDC_D_SETQ 4'h9
// menu item ids
`define PMDC_I_EDIT 4'h0
`define PMDC_I_SER 4'h1
`define PMDC_I_PASS 4'h2
`define PMDC_I_ROLE 4'h3
`define PMDC_I_TMO 4'h4
`define PMDC_I_FOL 4'h5
`define PMDC_I_POL 4'h6
`define PMDC_I_PER 4'h7
`define PMDC_I_ADDR 4'h8
`endif

// ---- core/pmdc_core.v ----
// panel menu, passcode, editing and display supervision
`timescale 1ns/1ps
`include "pmdc_defs.vh"
module pmdc_core #(
  parameter SIX_DEC = 0,
  parameter [31:0] DEB_CYC = `PMDC_DEB_MS * `PMDC_CLK_KHZ,
  parameter [31:0] LONG_CYC = `PMDC_LONG_MS * `PMDC_CLK_KHZ,
  parameter [31:0] SEC_CYC = `PMDC_SEC_MS * `PMDC_CLK_KHZ,
  parameter [31:0] ID_CYC = `PMDC_ID_MS * `PMDC_CLK_KHZ,
  parameter [31:0] ERR_CYC = `PMDC_ERR_MS * `PMDC_CLK_KHZ,
  parameter [31:0] SLIDE_CYC = `PMDC_SLIDE_MS * `PMDC_CLK_KHZ,
  // identity and version word, value arbitrary
  parameter [31:0] ID_WORD = 32'h0000_5a3c
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // keys, high while pressed
  input wire key_back,
  input wire key_enter,
  input wire key_up,
  input wire key_down,
  // serial engine
  input wire val_write,
  input wire poll_answer,
  input wire [31:0] value_in,
  output reg poll_req,
  // display
  output reg [3:0] disp_code,
  output reg [31:0] disp_value,
  output reg disp_blink,
  output reg [2:0] disp_digit,
  output reg disp_mask,
  // nonvolatile store request
  output reg nv_store,
  output reg [3:0] nv_item,
  output reg [15:0] nv_value,
  // register bus
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);

localparam [2:0] S_ID = 3'h0;
localparam [2:0] S_DISP = 3'h1;
localparam [2:0] S_PASS = 3'h2;
localparam [2:0] S_ERR = 3'h3;
localparam [2:0] S_MENU = 3'h4;
localparam [2:0] S_EDIT = 3'h5;
localparam [2:0] S_SETQ = 3'h6;
localparam [5:0] IDLE_CNT = `PMDC_IDLE_S;
localparam [31:0] HI = SIX_DEC ? `PMDC_HI6 : `PMDC_HI4;
localparam [31:0] LO = SIX_DEC ? `PMDC_LO6 : `PMDC_LO4;

function [15:0] pow10;
  input [1:0] p;
  case (p)
    2'h0: pow10 = 16'h0001;
    2'h1: pow10 = 16'h000A;
    2'h2: pow10 = 16'h0064;
    default: pow10 = 16'h03E8;
  endcase
endfunction

// the role submenu id follows the active role
function [3:0] item_id;
  input [1:0] l;
  input [1:0] x;
  input r;
  case (l)
    2'h0: item_id = (x == 2'h0) ? `PMDC_I_EDIT :
      (x == 2'h1) ? `PMDC_I_SER : `PMDC_I_PASS;
    2'h1: item_id = (x == 2'h0) ? `PMDC_I_ROLE :
      (x == 2'h1) ? `PMDC_I_TMO : (r ? `PMDC_I_POL : `PMDC_I_FOL);
    default: item_id = r ? `PMDC_I_PER : `PMDC_I_ADDR;
  endcase
endfunction

function [15:0] item_max;
  input [3:0] id;
  case (id)
    `PMDC_I_TMO: item_max = `PMDC_MAX_TMO;
    `PMDC_I_ADDR: item_max = 16'h00C7;
    `PMDC_I_PER: item_max = 16'h270F;
    `PMDC_I_PASS: item_max = 16'h270F;
    default: item_max = 16'h0001;
  endcase
endfunction

function is_list;
  input [3:0] id;
  is_list = (id == `PMDC_I_EDIT) || (id == `PMDC_I_ROLE);
endfunction

function is_sub;
  input [3:0] id;
  is_sub = (id == `PMDC_I_SER) || (id == `PMDC_I_FOL) ||
    (id == `PMDC_I_POL);
endfunction

integer i;
integer j;
reg [3:0] k_st;
reg [3:0] k_pv;
reg [31:0] deb [0:3];
reg [31:0] hold [0:3];
reg [31:0] sec_cnt;
reg sec_tick;
reg [2:0] st;
reg [31:0] tcnt;
reg [1:0] lvl;
reg [1:0] idx;
reg [15:0] ev;
reg [1:0] epos;
reg [5:0] idle;
reg cfg_role;
reg cfg_slide;
reg [15:0] cfg_pass;
reg [6:0] cfg_tmo;
reg [13:0] cfg_per;
reg [7:0] cfg_addr;
reg [31:0] s_tmr;
reg [1:0] s_rate;
reg [2:0] s_stp;
reg s_up;
reg [15:0] sup_cnt;
reg [13:0] poll_cnt;
reg blink;
reg have_val;
reg [31:0] val;
reg [15:0] cur_val;
reg [31:0] rd_mux;

wire [3:0] k_raw = {key_down, key_up, key_enter, key_back};
wire [3:0] prs = k_st & ~k_pv;
wire [3:0] rel = ~k_st & k_pv;
wire [3:0] sht;
wire [3:0] lng;
wire [3:0] cur_id = item_id(lvl, idx, cfg_role);
wire [15:0] mx = item_max(cur_id);
wire [1:0] cnt = (lvl == 2'h2) ? 2'h1 : 2'h3;
wire [15:0] pw = pow10(epos);
wire upd = cfg_role ? poll_answer : val_write;
wire [15:0] lim = {9'h000, cfg_tmo} + (cfg_role ? {2'h0, cfg_per} : 16'h0000);
// a fresh press with the other key released steers its own first step, not the stored direction
wire s_dir = (prs[2] && !k_st[3]) || (s_up && !(prs[3] && !k_st[2]));

genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : g_key
    assign sht[g] = rel[g] && (hold[g] < LONG_CYC);
    assign lng[g] = k_st[g] && (hold[g] == LONG_CYC - 32'h0000_0001);
  end
endgenerate

// debounce: a level must stay changed for the whole window
always @(posedge core_clk) begin
  for (i = 0; i < 4; i = i + 1) begin
    if (!rst_n) begin
      deb[i] <= 32'h0000_0000;
      hold[i] <= 32'h0000_0000;
    end else begin
      if (k_raw[i] == k_st[i])
        deb[i] <= 32'h0000_0000;
      else if (deb[i] >= DEB_CYC - 32'h0000_0001)
        deb[i] <= 32'h0000_0000;
      else
        deb[i] <= deb[i] + 32'h0000_0001;
      if (!k_st[i])
        hold[i] <= 32'h0000_0000;
      else if (hold[i] < LONG_CYC)
        hold[i] <= hold[i] + 32'h0000_0001;
    end
  end
end

always @(posedge core_clk) begin
  if (!rst_n) begin
    k_st <= 4'h0;
    k_pv <= 4'h0;
    sec_cnt <= 32'h0000_0000;
    sec_tick <= 1'b0;
  end else begin
    k_pv <= k_st;
    for (j = 0; j < 4; j = j + 1)
      if (k_raw[j] != k_st[j] && deb[j] >= DEB_CYC - 32'h0000_0001)
        k_st[j] <= k_raw[j];
    sec_tick <= (sec_cnt == SEC_CYC - 32'h0000_0001);
    if (sec_cnt == SEC_CYC - 32'h0000_0001)
      sec_cnt <= 32'h0000_0000;
    else
      sec_cnt <= sec_cnt + 32'h0000_0001;
  end
end

always @* begin
  case (cur_id)
    `PMDC_I_EDIT: cur_val = {15'h0000, cfg_slide};
    `PMDC_I_ROLE: cur_val = {15'h0000, cfg_role};
    `PMDC_I_TMO: cur_val = {9'h000, cfg_tmo};
    `PMDC_I_PER: cur_val = {2'h0, cfg_per};
    `PMDC_I_ADDR: cur_val = {8'h00, cfg_addr};
    `PMDC_I_PASS: cur_val = cfg_pass;
    default: cur_val = 16'h0000;
  endcase
end

always @* begin
  case (avs_address)
    `PMDC_A_CTRL: rd_mux = {30'h0000_0000, cfg_slide, cfg_role};
    `PMDC_A_PASS: rd_mux = {16'h0000, cfg_pass};
    `PMDC_A_TMO: rd_mux = {25'h000_0000, cfg_tmo};
    `PMDC_A_PER: rd_mux = {18'h0_0000, cfg_per};
    `PMDC_A_ADDR: rd_mux = {24'h00_0000, cfg_addr};
    `PMDC_A_STAT: rd_mux = {23'h00_0000, st, blink, have_val,
      lvl, idx};
    default: rd_mux = 32'h0000_0000;
  endcase
end

// value supervision runs in every state, menu included
always @(posedge core_clk) begin
  if (!rst_n) begin
    sup_cnt <= 16'h0000;
    poll_cnt <= 14'h0000;
    poll_req <= 1'b0;
    blink <= 1'b0;
    have_val <= 1'b0;
    val <= 32'h0000_0000;
  end else begin
    poll_req <= 1'b0;
    if (upd) begin
      val <= value_in;
      have_val <= 1'b1;
      sup_cnt <= 16'h0000;
      blink <= 1'b0;
    end else begin
      if (sec_tick && sup_cnt != 16'hFFFF)
        sup_cnt <= sup_cnt + 16'h0001;
      blink <= (cfg_tmo != 7'h00) && (sup_cnt > lim);
    end
    if (!cfg_role)
      poll_cnt <= 14'h0000;
    else if (sec_tick) begin
      if (poll_cnt + 14'h0001 >= cfg_per) begin
        poll_cnt <= 14'h0000;
        poll_req <= 1'b1;
      end else
        poll_cnt <= poll_cnt + 14'h0001;
    end
  end
end

always @(posedge core_clk) begin
  if (!rst_n) begin
    st <= S_ID;
    tcnt <= 32'h0000_0000;
    lvl <= 2'h0;
    idx <= 2'h0;
    ev <= 16'h0000;
    epos <= 2'h3;
    idle <= 6'h00;
    nv_store <= 1'b0;
    nv_item <= 4'h0;
    nv_value <= 16'h0000;
    cfg_role <= 1'b0;
    cfg_slide <= 1'b0;
    cfg_pass <= 16'h0000;
    cfg_tmo <= 7'h00;
    cfg_per <= `PMDC_RST_PER;
    cfg_addr <= `PMDC_RST_ADDR;
    s_tmr <= 32'h0000_0000;
    s_rate <= 2'h0;
    s_stp <= 3'h0;
    s_up <= 1'b1;
    avs_waitrequest <= 1'b1;
    avs_readdata <= 32'h0000_0000;
  end else begin
    nv_store <= 1'b0;
    // one wait state, then the answer for a single edge
    if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end else
      avs_waitrequest <= 1'b1;
    if (avs_write && !avs_waitrequest) begin
      case (avs_address)
        `PMDC_A_CTRL: begin
          cfg_role <= avs_writedata[`PMDC_CTRL_ROLE];
          cfg_slide <= avs_writedata[`PMDC_CTRL_SLIDE];
        end
        `PMDC_A_PASS: cfg_pass <= avs_writedata[15:0];
        `PMDC_A_TMO: cfg_tmo <= (avs_writedata > 32'h0000_0063) ?
          7'h63 : avs_writedata[6:0];
        `PMDC_A_PER: cfg_per <= avs_writedata[13:0];
        `PMDC_A_ADDR: cfg_addr <= avs_writedata[7:0];
        default: ;
      endcase
    end
    if (|(prs | rel))
      idle <= 6'h00;
    else if (sec_tick && idle != 6'h3F)
      idle <= idle + 6'h01;
    case (st)
      S_ID: begin
        if (tcnt >= ID_CYC - 32'h0000_0001) begin
          st <= S_DISP;
          tcnt <= 32'h0000_0000;
        end else
          tcnt <= tcnt + 32'h0000_0001;
      end
      S_DISP: begin
        if (lng[0]) begin
          lvl <= 2'h0;
          idx <= 2'h0;
          ev <= 16'h0000;
          epos <= 2'h3;
          st <= (cfg_pass == 16'h0000) ? S_MENU : S_PASS;
        end
      end
      S_PASS: begin
        if (prs[2] && ev + pw <= 16'h270F && ev / pw % 16'h000A != 9)
          ev <= ev + pw;
        else if (prs[3] && ev / pw % 16'h000A != 0)
          ev <= ev - pw;
        if (sht[1]) begin
          if (epos == 2'h0) begin
            st <= (ev == cfg_pass) ? S_MENU : S_ERR;
            tcnt <= 32'h0000_0000;
          end else
            epos <= epos - 2'h1;
        end
        if (sht[0])
          st <= S_DISP;
      end
      S_ERR: begin
        if (tcnt >= ERR_CYC - 32'h0000_0001)
          st <= S_DISP;
        else
          tcnt <= tcnt + 32'h0000_0001;
      end
      S_MENU: begin
        if (prs[2])
          idx <= (idx == cnt - 2'h1) ? 2'h0 : idx + 2'h1;
        else if (prs[3])
          idx <= (idx == 2'h0) ? cnt - 2'h1 : idx - 2'h1;
        if (sht[1]) begin
          if (is_sub(cur_id)) begin
            lvl <= lvl + 2'h1;
            idx <= 2'h0;
          end else begin
            ev <= cur_val;
            epos <= 2'h3;
            s_tmr <= 32'h0000_0000;
            s_rate <= 2'h0;
            st <= S_EDIT;
          end
        end
        if (sht[0]) begin
          idx <= 2'h0;
          if (lvl == 2'h0)
            st <= S_DISP;
          else
            lvl <= lvl - 2'h1;
        end
        if (idle >= IDLE_CNT)
          st <= S_DISP;
      end
      S_EDIT: begin
        if (is_list(cur_id)) begin
          if (prs[2] || prs[3])
            ev <= {15'h0000, ~ev[0]};
          if (sht[1])
            st <= S_SETQ;
        end else begin
          if (lng[1])
            st <= S_SETQ;
          if (!cfg_slide) begin
            if (sht[1])
              epos <= epos - 2'h1;
            if (prs[2] && ev + pw <= mx)
              ev <= ev + pw;
            else if (prs[3] && ev >= pw)
              ev <= ev - pw;
          end else begin
            if (prs[2] && !k_st[3])
              s_up <= 1'b1;
            if (prs[3] && !k_st[2])
              s_up <= 1'b0;
            if (!k_st[2] && !k_st[3]) begin
              s_tmr <= SLIDE_CYC; // first press steps at once
              s_rate <= 2'h0;
              s_stp <= 3'h0;
            end else if (s_tmr >= (SLIDE_CYC >> s_rate)) begin
              s_tmr <= 32'h0000_0000;
              s_stp <= s_stp + 3'h1;
              if (s_dir)
                ev <= (ev >= mx) ? mx : ev + 16'h0001;
              else
                ev <= (ev == 16'h0000) ? ev : ev - 16'h0001;
              // holding the other key keeps the slow rate
              if (k_st[2] && k_st[3])
                s_rate <= 2'h0;
              else if (s_stp == 3'h7 && s_rate != 2'h3)
                s_rate <= s_rate + 2'h1;
            end else
              s_tmr <= s_tmr + 32'h0000_0001;
            if ((prs[3] && k_st[2]) || (prs[2] && k_st[3]))
              s_rate <= 2'h0;
          end
        end
        if (sht[0])
          st <= S_MENU;
      end
      S_SETQ: begin
        if (sht[1]) begin
          nv_store <= 1'b1;
          nv_item <= cur_id;
          nv_value <= ev;
          st <= S_MENU;
          case (cur_id)
            `PMDC_I_EDIT: cfg_slide <= ev[0];
            `PMDC_I_ROLE: cfg_role <= ev[0];
            `PMDC_I_TMO: cfg_tmo <= ev[6:0];
            `PMDC_I_PER: cfg_per <= ev[13:0];
            `PMDC_I_ADDR: cfg_addr <= ev[7:0];
            `PMDC_I_PASS: cfg_pass <= ev;
            default: ;
          endcase
        end else if (sht[0])
          st <= S_MENU;
      end
      default: st <= S_ID;
    endcase
  end
end

always @(posedge core_clk) begin
  if (!rst_n) begin
    disp_code <= `PMDC_D_ID;
    disp_value <= 32'h0000_0000;
    disp_blink <= 1'b0;
    disp_digit <= 3'h7;
    disp_mask <= 1'b0;
  end else begin
    disp_blink <= 1'b0;
    disp_digit <= 3'h7;
    disp_mask <= 1'b0;
    disp_value <= {16'h0000, ev};
    case (st)
      S_ID: begin
        disp_code <= `PMDC_D_ID;
        disp_value <= ID_WORD;
      end
      S_DISP: begin
        disp_value <= val;
        if (!have_val)
          disp_code <= `PMDC_D_DASH;
        else if ($signed(val) > $signed(HI))
          disp_code <= `PMDC_D_OVER;
        else if ($signed(val) < $signed(LO))
          disp_code <= `PMDC_D_UNDER;
        else begin
          disp_code <= `PMDC_D_VAL;
          disp_blink <= blink;
        end
      end
      S_PASS: begin
        disp_code <= `PMDC_D_PASS;
        disp_digit <= {1'b0, epos};
        disp_mask <= 1'b1;
      end
      S_ERR: disp_code <= `PMDC_D_ERR;
      S_MENU: begin
        disp_code <= `PMDC_D_ITEM;
        disp_value <= {28'h000_0000, cur_id};
      end
      S_EDIT: begin
        disp_code <= `PMDC_D_EDIT;
        if (!cfg_slide && !is_list(cur_id))
          disp_digit <= {1'b0, epos};
      end
      S_SETQ: disp_code <= `PMDC_D_SETQ;
      default: disp_code <= `PMDC_D_ID;
    endcase
  end
end

endmodule // pmdc_core

// ---- test/pmdc_core_sva.sv ----
// assertion checker for the panel menu and display block
`timescale 1ns/1ps
`include "pmdc_defs.vh"
module pmdc_core_sva #(
  parameter [31:0] SEC_CYC = 32'h0000_0032,
  parameter [31:0] ID_CYC = 32'h0000_000a
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // keys
  input wire key_back,
  input wire key_enter,
  input wire key_up,
  input wire key_down,
  // serial engine
  input wire val_write,
  input wire poll_answer,
  input wire [31:0] value_in,
  input wire poll_req,
  // display and store
  input wire [3:0] disp_code,
  input wire disp_blink,
  input wire disp_mask,
  input wire nv_store,
  // register bus
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest
);
  // one slack second for the free tick, one for the key debounce
  localparam [31:0] IDLE_MAX = 62 * SEC_CYC;
  reg poller;
  reg [31:0] id_cnt;
  reg [31:0] idle_cnt;
  wire any_key = key_back | key_enter | key_up | key_down;
  wire shown = disp_code >= `PMDC_D_DASH && disp_code <= `PMDC_D_UNDER;
  wire fol_wr = !poller && shown && val_write;
  // role tracked from bus writes only; menu commits of role not seen
  always @(posedge core_clk) begin
    if (!rst_n) begin
      poller <= 1'b0;
      id_cnt <= 32'h0000_0000;
      idle_cnt <= 32'h0000_0000;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `PMDC_A_CTRL) begin
        poller <= avs_writedata[`PMDC_CTRL_ROLE];
      end
      id_cnt <= (disp_code == `PMDC_D_ID) ? id_cnt + 1 : 32'h0000_0000;
      idle_cnt <= (disp_code == `PMDC_D_ITEM && !any_key) ?
                  idle_cnt + 1 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_id_len;
    id_cnt <= ID_CYC + 4;
  endproperty
  a_id_len: assert property (p_id_len) else $error("id shown too long");
  property p_id_dash;
    (disp_code == `PMDC_D_ID) ##1 (disp_code != `PMDC_D_ID)
      |-> disp_code == `PMDC_D_DASH;
  endproperty
  a_id_dash: assert property (p_id_dash) else $error("no dashes after id");
  property p_over;
    fol_wr && $signed(value_in) > $signed(`PMDC_HI4)
      |-> ##[1:3] disp_code == `PMDC_D_OVER;
  endproperty
  a_over: assert property (p_over) else $error("over range not shown");
  property p_under;
    fol_wr && $signed(value_in) < $signed(`PMDC_LO4)
      |-> ##[1:3] disp_code == `PMDC_D_UNDER;
  endproperty
  a_under: assert property (p_under) else $error("under range not shown");
  property p_inrange;
    fol_wr && $signed(value_in) <= $signed(`PMDC_HI4) &&
      $signed(value_in) >= $signed(`PMDC_LO4)
      |-> ##[1:3] disp_code == `PMDC_D_VAL;
  endproperty
  a_inrange: assert property (p_inrange) else $error("value not shown");
  property p_fol_clear;
    !poller && val_write |-> ##[1:3] !disp_blink;
  endproperty
  a_fol_clear: assert property (p_fol_clear) else $error("blink kept");
  property p_pol_clear;
    poller && poll_answer |-> ##[1:3] !disp_blink;
  endproperty
  a_pol_clear: assert property (p_pol_clear) else $error("blink kept");
  property p_poll_gap;
    poll_req |=> !poll_req [*8];
  endproperty
  a_poll_gap: assert property (p_poll_gap) else $error("poll too soon");
  property p_mask;
    disp_mask |-> disp_code == `PMDC_D_PASS;
  endproperty
  a_mask: assert property (p_mask) else $error("mask outside passcode");
  property p_idle;
    idle_cnt <= IDLE_MAX;
  endproperty
  a_idle: assert property (p_idle) else $error("menu idle too long");
  property p_store_menu;
    nv_store |-> ##[0:4] disp_code == `PMDC_D_ITEM;
  endproperty
  a_store_menu: assert property (p_store_menu) else $error("no menu");
endmodule // pmdc_core_sva

// ---- test/pmdc_operator.sv ----
// operator model pressing the front-panel keys
`timescale 1ns/1ps
module pmdc_operator #(
  parameter int GAP = 16
) (
  // clock
  input logic core_clk,
  // command from the bench
  input logic go,
  input logic [3:0] keys,
  input logic [15:0] hold,
  // keys to the block
  output logic key_back,
  output logic key_enter,
  output logic key_up,
  output logic key_down,
  output logic busy
);
  logic on = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [3:0] pins;
  // contact bounce on cycle 1, the block has to filter it
  assign pins = (on && cnt < hold && cnt != 16'h0001) ? sel : 4'h0;
  assign {key_down, key_up, key_enter, key_back} = pins;
  assign busy = on;
  always @(posedge core_clk) begin
    if (go) begin
      on <= 1'b1;
      sel <= keys;
      cnt <= 16'h0000;
    end else if (on) begin
      cnt <= cnt + 16'h0001;
      if (cnt == hold + GAP) begin
        on <= 1'b0;
      end
    end
  end
endmodule // pmdc_operator

// ---- test/tb.sv ----
// self-checking bench for the panel menu and display block
`timescale 1ns/1ps
`include "pmdc_defs.vh"
module tb;
  localparam [31:0] SEC = 32'h0000_0032;
  localparam [3:0] BK = 4'h1, EN = 4'h2, UP = 4'h4, DN = 4'h8;
  localparam int SH = 10, LG = 60;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic val_write = 1'b0;
  logic poll_answer = 1'b0;
  logic [31:0] value_in = 32'h0000_0000;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic op_go = 1'b0;
  logic [3:0] op_keys = 4'h0;
  logic [15:0] op_hold = 16'h0000;
  wire key_back, key_enter, key_up, key_down, op_busy;
  wire poll_req, disp_blink, disp_mask, nv_store, avs_waitrequest;
  wire [3:0] disp_code, nv_item;
  wire [31:0] disp_value, avs_readdata;
  wire [2:0] disp_digit;
  wire [15:0] nv_value;
  int num_errors = 0;
  int num_checks = 0;
  int n_poll = 0;
  int n_store = 0;
  int vals[$];
  int p0, d, e;
  logic [31:0] rnd = 32'ha071_2784;
  logic [31:0] rd;
  logic [15:0] seen, st_val;
  logic [3:0] st_item;
  pmdc_core #(.DEB_CYC(32'h0000_0004), .LONG_CYC(32'h0000_0028),
    .SEC_CYC(SEC), .ID_CYC(32'h0000_000a), .ERR_CYC(32'h0000_0064),
    .SLIDE_CYC(32'h0000_0010)) u_pmdc_core (.core_clk, .rst_n,
    .key_back, .key_enter, .key_up, .key_down, .val_write, .poll_answer,
    .value_in, .poll_req, .disp_code, .disp_value, .disp_blink,
    .disp_digit, .disp_mask, .nv_store, .nv_item, .nv_value,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  pmdc_operator u_pmdc_operator (.core_clk, .go(op_go), .keys(op_keys),
    .hold(op_hold), .key_back, .key_enter, .key_up, .key_down,
    .busy(op_busy));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (poll_req === 1'b1) n_poll <= n_poll + 1;
    if (nv_store === 1'b1) begin
      n_store <= n_store + 1;
      st_item <= nv_item;
      st_val <= nv_value;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] cls(input int x);
    if (x > 9999) return `PMDC_D_OVER;
    if (x < -999) return `PMDC_D_UNDER;
    return `PMDC_D_VAL;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    test_done();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [3:0] c);
    chk({28'h0000_000, disp_code}, {28'h0000_000, c});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] dat);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= dat;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) hang();
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wait_code(input logic [3:0] c, input int n);
    int i;
    for (i = 0; i < n && disp_code !== c; i++) @(posedge core_clk);
    chk_code(c);
    if (i == n) hang();
  endtask
  task automatic press(input logic [3:0] k, input int h);
    int i;
    @(posedge core_clk);
    op_go <= 1'b1;
    op_keys <= k;
    op_hold <= h[15:0];
    @(posedge core_clk);
    op_go <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge core_clk);
      if (op_busy === 1'b0) break;
    end
    if (i == 400) hang();
  endtask
  // the serial engine hands over one value, as follower write or answer
  task automatic put(input logic ans, input int x);
    @(posedge core_clk);
    val_write <= !ans;
    poll_answer <= ans;
    value_in <= x;
    @(posedge core_clk);
    val_write <= 1'b0;
    poll_answer <= 1'b0;
    tick(4);
    chk_code(cls(x));
    if (cls(x) == `PMDC_D_VAL) chk(disp_value, x);
  endtask
  task automatic seek(input logic [3:0] id);
    for (int i = 0; i < 12 && disp_value !== {28'h0000_000, id}; i++)
      press(DN, SH);
    chk(disp_value, {28'h0000_000, id});
  endtask
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(3);
    chk_code(`PMDC_D_ID);
    chk(disp_value, 32'h0000_5a3c);
    wait_code(`PMDC_D_DASH, 40);
    rdchk(`PMDC_A_PER, 32'h0000_0001);
    rdchk(`PMDC_A_ADDR, 32'h0000_0001);
    bus(1'b1, 5'h18, 32'hffff_ffff);
    rdchk(5'h18, 32'h0000_0000);
    bus(1'b1, `PMDC_A_TMO, 32'h0000_00c8);
    rdchk(`PMDC_A_TMO, 32'h0000_0063);
    bus(1'b1, `PMDC_A_TMO, 32'h0000_0002);
    vals = '{9999, 10000, -999, -1000};
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      vals.push_back(int'(rnd % 32'h0000_36b0) - 2000);
    end
    foreach (vals[i]) put(1'b0, vals[i]);
    tick(80);
    chk({31'h0, disp_blink}, 32'h0000_0000);
    tick(170);
    chk({31'h0, disp_blink}, 32'h0000_0001);
    put(1'b0, 42);
    chk({31'h0, disp_blink}, 32'h0000_0000);
    bus(1'b1, `PMDC_A_TMO, 32'h0000_0000);
    tick(300);
    chk({31'h0, disp_blink}, 32'h0000_0000);
    bus(1'b1, `PMDC_A_TMO, 32'h0000_0002);
    bus(1'b1, `PMDC_A_CTRL, 32'h0000_0001);
    p0 = n_poll;
    tick(500);
    chk({31'h0, (n_poll - p0) inside {[9:11]}}, 32'h0000_0001);
    put(1'b1, 55);
    tick(140);
    chk({31'h0, disp_blink}, 32'h0000_0000);
    tick(160);
    chk({31'h0, disp_blink}, 32'h0000_0001);
    put(1'b1, 66);
    chk({31'h0, disp_blink}, 32'h0000_0000);
    bus(1'b1, `PMDC_A_CTRL, 32'h0000_0000);
    bus(1'b1, `PMDC_A_TMO, 32'h0000_0000);
    press(BK, SH);
    chk_code(`PMDC_D_VAL);
    press(BK, LG);
    chk_code(`PMDC_D_ITEM);
    seek(`PMDC_I_SER);
    press(EN, SH);
    chk_code(`PMDC_D_ITEM);
    seen = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      seen[disp_value[3:0]] = 1'b1;
      press(UP, SH);
    end
    chk({31'h0, seen[`PMDC_I_FOL]}, 32'h0000_0001);
    chk({31'h0, seen[`PMDC_I_POL]}, 32'h0000_0000);
    seek(`PMDC_I_TMO);
    press(EN, SH);
    chk_code(`PMDC_D_EDIT);
    chk(disp_value, 32'h0000_0000);
    d = int'(disp_digit) % 4;
    e = (10 ** d <= 99) ? 10 ** d : 0;
    press(UP, SH);
    chk(disp_value, e);
    press(EN, SH);
    chk({29'h0, disp_digit}, (d + 3) % 4);
    press(EN, SH);
    d = (d + 2) % 4;
    e = (e + 10 ** d <= 99) ? e + 10 ** d : e;
    press(UP, SH);
    chk(disp_value, e);
    p0 = n_store;
    press(EN, LG);
    chk_code(`PMDC_D_SETQ);
    press(EN, SH);
    chk_code(`PMDC_D_ITEM);
    chk(n_store - p0, 32'h0000_0001);
    chk({28'h0, st_item}, {28'h0, `PMDC_I_TMO});
    chk({16'h0, st_val}, e);
    bus(1'b1, `PMDC_A_TMO, 32'h0000_0000);
    seek(`PMDC_I_ROLE);
    press(EN, SH);
    press(UP, SH);
    press(EN, SH);
    chk_code(`PMDC_D_SETQ);
    p0 = n_store;
    press(BK, SH);
    chk_code(`PMDC_D_ITEM);
    chk(n_store - p0, 32'h0000_0000);
    bus(1'b1, `PMDC_A_CTRL, 32'h0000_0002);
    seek(`PMDC_I_TMO);
    press(EN, SH);
    press(UP, 100);
    chk({29'h0, disp_digit}, 32'h0000_0007);
    e = int'(disp_value);
    chk({31'h0, e inside {[3:8]}}, 32'h0000_0001);
    press(DN, SH);
    chk(disp_value, e - 1);
    press(BK, SH);
    bus(1'b1, `PMDC_A_CTRL, 32'h0000_0000);
    press(BK, SH);
    press(BK, SH);
    chk_code(`PMDC_D_VAL);
    press(BK, LG);
    tick(55 * SEC);
    chk_code(`PMDC_D_ITEM);
    wait_code(`PMDC_D_VAL, 8 * SEC);
    bus(1'b1, `PMDC_A_PASS, 32'h0000_03e8);
    press(BK, LG);
    chk_code(`PMDC_D_PASS);
    chk({31'h0, disp_mask}, 32'h0000_0001);
    repeat (4) press(EN, SH);
    chk_code(`PMDC_D_ERR);
    wait_code(`PMDC_D_VAL, 200);
    press(BK, LG);
    press(UP, SH);
    repeat (4) press(EN, SH);
    chk_code(`PMDC_D_ITEM);
    press(BK, SH);
    test_done();
  end
endmodule // tb
bind pmdc_core pmdc_core_sva #(.SEC_CYC(SEC_CYC), .ID_CYC(ID_CYC))
  u_pmdc_core_sva (.core_clk, .rst_n, .key_back, .key_enter, .key_up,
  .key_down, .val_write, .poll_answer, .value_in, .poll_req, .disp_code,
  .disp_blink, .disp_mask, .nv_store, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest);
